// ---- design/trace_powerdown_status.sv ----
// power domain status register: lock state, core power and sticky state-lost flag
//
// Contract
// - 32-bit read-only, reserved bits read zero
// - bit 5 shows os lock state
// - reset forces lock status bit to one
// - lock bit undefined while unpowered
// - no lock feature ties bit 5 low
// - bit 1 is sticky state-lost flag
// - reset sets sticky flag
// - power removal with loss sets flag
// - read returns flag then clears it
// - locked memory-mapped read keeps flag
// - read while unpowered keeps flag
// - bit 0 reports core domain power
// - other registers error while unpowered
// - unified power domain hardwires bit 0
// - reachable only by memory-mapped or debugger
// - retention restores flag value from before
// - lost state shows flag set on return
`timescale 1ns/100ps
`include "trace_pd_map.svh"
module trace_powerdown_status
   import trace_pd_pkg::*;
#(
   parameter bit HAS_OS_LOCK = 1'b1,
   parameter bit UNIFIED_POWER = 1'b0,
   parameter bit HAS_SW_LOCK = 1'b1
) (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire rd_req_t rd_req_i,
   output rd_rsp_t rd_rsp_o,
   input wire logic os_lock_i,
   input wire logic sw_locked_i,
   input wire logic power_good_i,
   input wire logic state_retained_i,
   output logic regs_error_o
);
   // the three status fields must sit apart inside one 32-bit word
   initial begin
      if (`PDS_BIT_POWER == `PDS_BIT_STICKY || `PDS_BIT_STICKY == `PDS_BIT_OSLOCK
         || `PDS_BIT_POWER == `PDS_BIT_OSLOCK) begin
         $error("trace_powerdown_status: status fields overlap");
      end
      if (`PDS_BIT_OSLOCK > 31 || `PDS_BIT_STICKY > 31 || `PDS_BIT_POWER > 31) begin
         $error("trace_powerdown_status: status field outside the word");
      end
   end

   logic pg_meta;
   logic pg_sync;
   logic power_q;
   logic ret_q;
   logic sticky;
   logic oslock;
   logic power_now;
   logic rd_hit;
   logic rd_clear;
   logic power_fall;
   logic power_rise;
   logic ret_flag;
   logic lock_shown;

   // one place builds the word so reserved bits cannot pick up stray values
   function automatic logic [31:0] status_word(input logic lock_bit, input logic flag_bit,
      input logic power_bit);
      logic [31:0] word;
      word = 32'h0;
      word[`PDS_BIT_OSLOCK] = lock_bit;
      word[`PDS_BIT_STICKY] = flag_bit;
      word[`PDS_BIT_POWER] = power_bit;
      return word;
   endfunction : status_word

   // two stages before anyone looks at the power-good pin
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pg_meta <= 1'b0;
         pg_sync <= 1'b0;
         ret_q <= 1'b0;
      end else if (ce_i) begin
         pg_meta <= power_good_i;
         pg_sync <= pg_meta;
         ret_q <= state_retained_i;
      end
   end

   assign power_now = UNIFIED_POWER ? 1'b1 : pg_sync;

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         power_q <= 1'b0;
      end else if (ce_i) begin
         power_q <= power_now;
      end
   end

   assign power_fall = power_q && !power_now;
   assign power_rise = !power_q && power_now;
   // only reads presented here (memory-mapped or debugger port) reach the register
   assign rd_hit = rd_req_i.valid && (rd_req_i.addr == `PDS_OFFSET);
   assign rd_clear = rd_hit && power_now
      && !(rd_req_i.mem_mapped && HAS_SW_LOCK && sw_locked_i);

   // retention copy taken as power drops; only read back if state survived
   retention_store #(.WIDTH(1)) u_ret (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .wr_i(power_fall),
      .wdata_i(sticky),
      .rdata_o(ret_flag)
   );

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sticky <= `PDS_RST_STICKY;
      end else if (ce_i) begin
         if (power_fall && !state_retained_i) begin
            sticky <= 1'b1;
         end else if (power_rise) begin
            sticky <= ret_q ? ret_flag : 1'b1;
         end else if (rd_clear) begin
            sticky <= 1'b0;
         end
      end
   end

   // lock value is only meaningful while powered; follows the lock source
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         oslock <= `PDS_RST_OSLOCK;
      end else if (ce_i && power_now) begin
         oslock <= os_lock_i;
      end
   end

   assign lock_shown = HAS_OS_LOCK ? oslock : 1'b0;

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rd_rsp_o <= '0;
         regs_error_o <= 1'b1;
      end else if (ce_i) begin
         regs_error_o <= !power_now;
         rd_rsp_o.valid <= rd_req_i.valid;
         rd_rsp_o.err <= rd_req_i.valid && !rd_hit && !power_now;
         if (rd_hit) begin
            rd_rsp_o.data <= status_word(lock_shown, sticky, power_now);
         end else begin
            rd_rsp_o.data <= 32'h0;
         end
      end
   end

   a_read_clears: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      ce_i && rd_clear && !power_fall && !power_rise |=> !sticky)
      else $error("sticky flag not cleared by read");
   a_locked_keeps: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      ce_i && rd_hit && rd_req_i.mem_mapped && sw_locked_i && HAS_SW_LOCK
      && power_q == power_now |=> sticky == $past(sticky))
      else $error("locked read altered flag");
   a_off_keeps: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      ce_i && !power_now && !power_q && rd_hit |=> sticky == $past(sticky))
      else $error("unpowered read altered flag");
   a_loss_sets: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      ce_i && power_fall && !state_retained_i |=> sticky)
      else $error("power loss did not set flag");
   a_data_reflects: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      ce_i && rd_hit |=> rd_rsp_o.valid && rd_rsp_o.data[1] == $past(sticky)
      && rd_rsp_o.data[31:6] == 26'h0 && rd_rsp_o.data[4:2] == 3'h0)
      else $error("read data mismatch");
   a_power_bit: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      ce_i && rd_hit |=> rd_rsp_o.data[0] == $past(power_now))
      else $error("power bit mismatch");
   a_error_off: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      ce_i && rd_req_i.valid && !rd_hit && !power_now |=> rd_rsp_o.err)
      else $error("missing error response");
   a_lost_return: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      ce_i && power_rise && !ret_q |=> sticky)
      else $error("flag not set after lost state");

   // response framing: one answer per taken request, none otherwise
   a_answer_follows: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      ce_i && rd_req_i.valid |=> rd_rsp_o.valid)
      else $error("read not answered one cycle later");
   a_no_stray_answer: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      ce_i && !rd_req_i.valid |=> !rd_rsp_o.valid && !rd_rsp_o.err)
      else $error("answer without a request");

   // other addresses and the error indication
   a_other_zero: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      ce_i && rd_req_i.valid && !rd_hit |=> rd_rsp_o.data == 32'h0)
      else $error("status bits leaked to another address");
   a_powered_ok: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      ce_i && power_now |=> !rd_rsp_o.err && !regs_error_o)
      else $error("error raised while powered");
   a_error_flag: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      ce_i && !power_now |=> regs_error_o)
      else $error("error flag low while unpowered");

   // lock copy and power detection
   a_lock_follows: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      ce_i && power_now |=> oslock == $past(os_lock_i))
      else $error("lock bit not following lock source");
   a_lock_holds: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      ce_i && !power_now |=> oslock == $past(oslock))
      else $error("lock bit moved while unpowered");
   a_power_from_pin: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      !UNIFIED_POWER && ce_i ##1 ce_i
      |=> power_now == $past(power_good_i, 2))
      else $error("power bit not two stages behind the pin");

   // sticky flag restore and freeze
   a_retain_restore: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      ce_i && power_rise && ret_q |=> sticky == $past(ret_flag))
      else $error("retained flag not restored");
   a_freeze_holds: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      !ce_i
      |=> sticky == $past(sticky) && rd_rsp_o == $past(rd_rsp_o))
      else $error("state moved while clock enable low");
endmodule : trace_powerdown_status

// ---- design/trace_pd_map.svh ----
// offsets, field positions and reset values of the power status register
`ifndef TRACE_PD_MAP_SVH
`define TRACE_PD_MAP_SVH
`define PDS_OFFSET 12'h314
`define PDS_BIT_POWER 0
`define PDS_BIT_STICKY 1
`define PDS_BIT_OSLOCK 5
`define PDS_RST_STICKY 1'h1
`define PDS_RST_OSLOCK 1'h1
`endif

// ---- design/trace_pd_pkg.sv ----
// types shared by the power status register block
package trace_pd_pkg;
   typedef struct packed {
      logic valid;
      logic [11:0] addr;
      logic mem_mapped;
   } rd_req_t;
   typedef struct packed {
      logic valid;
      logic err;
      logic [31:0] data;
   } rd_rsp_t;
endpackage : trace_pd_pkg

// ---- design/retention_store.sv ----
// one-word retention store holding the sticky flag across a retention power-down
`timescale 1ns/100ps
module retention_store #(
   parameter int WIDTH = 1
) (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic wr_i,
   input wire logic [WIDTH-1:0] wdata_i,
   output logic [WIDTH-1:0] rdata_o
);
   initial begin
      if (WIDTH < 1) $error("retention_store: WIDTH must be positive");
   end
   logic [WIDTH-1:0] mem;
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mem <= '1;
      end else if (ce_i && wr_i) begin
         mem <= wdata_i;
      end
   end
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_o <= '1;
      end else if (ce_i) begin
         rdata_o <= mem;
      end
   end
endmodule : retention_store

// ---- verification/bus_reader.sv ----
// bus master model issuing single reads of the status register or any other given address
`timescale 1ns/100ps
module bus_reader
   import trace_pd_pkg::*;
(
   input wire logic clk_sys_i,
   output rd_req_t rd_req_o,
   input wire rd_rsp_t rd_rsp_i
);
   initial rd_req_o = '0;
   // called just after a falling edge; the answer is taken one cycle after the request
   task automatic read(input logic [11:0] addr, input logic mm, output rd_rsp_t rsp);
      rd_req_o = '{valid: 1'b1, addr: addr, mem_mapped: mm};
      @(negedge clk_sys_i);
      rsp = rd_rsp_i;
      // released address shows the inverse, not the last value
      rd_req_o = '{valid: 1'b0, addr: ~addr, mem_mapped: ~mm};
      // one idle cycle so a following read never re-raises valid in this time step
      @(negedge clk_sys_i);
   endtask : read
endmodule : bus_reader

// ---- verification/test_trace_powerdown_status.sv ----
// self-checking bench for the power domain status register
`timescale 1ns/100ps
`include "trace_pd_map.svh"
module test_trace_powerdown_status;
   import trace_pd_pkg::*;
   logic clk_sys_i = 1'b0, rstn_i = 1'b0, os_lock = 1'b1, sw_locked = 1'b0;
   logic power_good = 1'b1, retained = 1'b0, regs_error, ce = 1'b1;
   rd_req_t rd_req;
   rd_rsp_t rd_rsp;
   int failures = 0, num_checks = 0;
   trace_powerdown_status trace_powerdown_status_inst (.clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i), .ce_i(ce), .rd_req_i(rd_req), .rd_rsp_o(rd_rsp),
      .os_lock_i(os_lock), .sw_locked_i(sw_locked), .power_good_i(power_good),
      .state_retained_i(retained), .regs_error_o(regs_error));
   bus_reader bus_reader_inst (.clk_sys_i(clk_sys_i), .rd_req_o(rd_req), .rd_rsp_i(rd_rsp));
   initial forever #25 clk_sys_i = ~clk_sys_i;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // read the status word, masked to the bits that are defined in this state
   task automatic rd_chk(input logic mm, input logic [31:0] mask, input logic [31:0] exp);
      rd_rsp_t r;
      bus_reader_inst.read(`PDS_OFFSET, mm, r);
      check({r.valid, r.err}, 32'h2);
      check(r.data & mask, exp);
   endtask : rd_chk
   // reads elsewhere never see status bits; unpowered they carry an error
   task automatic rd_other(input logic [31:0] exp_flags);
      rd_rsp_t r;
      bus_reader_inst.read(12'h000, 1'b0, r);
      check({r.valid, r.err}, exp_flags);
      check(r.data, 32'h0);
   endtask : rd_other
   task automatic settle();
      repeat (5) @(negedge clk_sys_i);
   endtask : settle
   task automatic do_reset();
      rstn_i = 1'b0;
      repeat (3) @(negedge clk_sys_i);
      rstn_i = 1'b1;
      settle();
   endtask : do_reset
   task automatic test_reset();
      do_reset();
      rd_chk(1'b0, 32'hffffffff, 32'h23);
      rd_chk(1'b0, 32'hffffffff, 32'h21);
      os_lock = 1'b0;
      // the lock copy needs one edge before a read can show it
      @(negedge clk_sys_i);
      rd_chk(1'b0, 32'hffffffff, 32'h01);
   endtask : test_reset
   task automatic test_sw_lock();
      do_reset();
      sw_locked = 1'b1;
      rd_chk(1'b1, 32'h3, 32'h3);
      rd_chk(1'b1, 32'h3, 32'h3);
      rd_chk(1'b0, 32'h3, 32'h3);
      rd_chk(1'b0, 32'h3, 32'h1);
      sw_locked = 1'b0;
   endtask : test_sw_lock
   task automatic test_power_loss();
      power_good = 1'b0;
      settle();
      check({31'h0, regs_error}, 32'h1);
      rd_other(32'h3);
      // lock bit is undefined while unpowered, so it is masked out
      rd_chk(1'b0, 32'h3, 32'h2);
      rd_chk(1'b0, 32'h3, 32'h2);
      power_good = 1'b1;
      settle();
      check({31'h0, regs_error}, 32'h0);
      rd_other(32'h2);
      rd_chk(1'b0, 32'hffffffff, 32'h03);
   endtask : test_power_loss
   task automatic power_cycle();
      power_good = 1'b0;
      settle();
      power_good = 1'b1;
      settle();
   endtask : power_cycle
   // retention is tried with the flag clear and with it set, so a stuck value shows
   task automatic test_retention();
      rd_rsp_t r;
      retained = 1'b1;
      power_cycle();
      rd_chk(1'b0, 32'hffffffff, 32'h01);
      do_reset();
      power_cycle();
      // frozen: the read is not taken, so no answer and the flag survives
      ce = 1'b0;
      bus_reader_inst.read(`PDS_OFFSET, 1'b0, r);
      check({r.valid, r.err}, 32'h0);
      ce = 1'b1;
      rd_chk(1'b0, 32'hffffffff, 32'h03);
      retained = 1'b0;
   endtask : test_retention
   task automatic finish_test();
      if (failures == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test
   initial begin
      test_reset();
      test_sw_lock();
      test_power_loss();
      test_retention();
      finish_test();
   end
   // the tests need about 85 cycles; this allows far more
   initial begin
      #30000;
      failures++;
      finish_test();
   end
endmodule : test_trace_powerdown_status
